//--- verilog/sfsl_sequencer.v
/*
 * serial flash instruction sequencer for security register read, per-unit
 * volatile locks and the two-step software reset.
 * assumes serial_clk_i, chip_sel_n_i and serial_in_i come from the host
 * pins asynchronously; they are synchronised and their edges found on
 * clock_i, which must run well above the serial clock.
 */
// Overview of operation
// - read: 48h, 24-bit address, eight dummies
// - sample serial input on rising clock
// - data out on falling edges, MSB first
// - address increments, wraps FFh to 00h
// - chip select high ends instruction
// - security read ignored while busy
// - address bits 13-12 pick register
// - per-unit locks only in lock mode
// - lock bits volatile, set after reset
// - 36h plus address locks one unit
// - 39h plus address unlocks one unit
// - lock commands need write enable latch
// - 3Dh shifts out lock value
// - 7Eh sets all lock bits
// - 98h clears all lock bits
// - reset needs 66h then 99h
// - other instruction cancels reset arm
// - reset sets all locks, clears write enable latch
// - no instruction during reset recovery
// - busy bit reports self-timed cycle
`timescale 1ns/1ns
`include "sfsl_map.vh"
module sfsl_sequencer #(
    parameter UNITS        = 32,
    parameter IDX_W        = 5,
    parameter UNIT_SHIFT   = 15,
    parameter RESET_CYCLES = `SFSL_RESET_CYCLES
) (
    input  wire             clock_i,
    input  wire             rst_n_i,
    input  wire             serial_clk_i,
    input  wire             chip_sel_n_i,
    input  wire             serial_in_i,
    input  wire             cycle_busy_i,
    input  wire             latch_set_i,
    input  wire             per_unit_lock_mode_i,
    input  wire             secreg_wr_en_i,
    input  wire [9:0]       secreg_wr_addr_i,
    input  wire [7:0]       secreg_wr_data_i,
    output reg              serial_out_o,
    output reg              serial_out_oe_o,
    output reg              write_enable_latch_o,
    output reg              busy_o,
    output reg              reset_pulse_o,
    output reg              protect_use_locks_o,
    output reg  [UNITS-1:0] lock_bits_o
);
    localparam ST_OPC   = 3'd0;    // shifting opcode
    localparam ST_ADDR  = 3'd1;    // shifting address
    localparam ST_DUMMY = 3'd2;    // dummy clocks
    localparam ST_DATA  = 3'd3;    // shifting out data
    localparam ST_IDLE  = 3'd4;    // ignore until chip select high
    localparam RCNT_W   = 24;

    reg  [1:0]        sclk_s;      // serial clock synchroniser
    reg  [1:0]        csn_s;       // chip select synchroniser
    reg  [1:0]        din_s;       // serial input synchroniser
    reg               sclk_q;      // previous synced clock
    reg               csn_q;       // previous synced select
    reg  [2:0]        state;       // frame state
    reg  [4:0]        bit_cnt;     // bits within field
    reg  [7:0]        opcode;      // received opcode
    reg  [23:0]       addr;        // received address
    reg  [7:0]        shift_out;   // outgoing byte
    reg               lock_read;   // output source is lock value
    reg               armed;       // reset armed
    reg               we_latch;    // write enable latch
    reg               in_reset;    // recovery in progress
    reg  [RCNT_W-1:0] rcnt;        // recovery counter
    reg               pend_one;    // single lock update pending
    reg               pend_val;    // lock value to store
    reg               pend_all;    // global update pending
    reg               do_set_one;  // strobes to lock store
    reg               do_clr_one;
    reg               do_set_all;
    reg               do_clr_all;
    reg               do_init;
    wire [7:0]        mem_q;       // security register byte
    wire [UNITS-1:0]  locks;       // lock store contents
    wire [IDX_W-1:0]  unit_idx;    // unit picked by address
    wire              rise;
    wire              fall;
    wire              cs_rise;
    wire              cs_fall;
    wire [7:0]        opc_next;
    wire [23:0]       addr_next;
    wire [9:0]        mem_addr;

    // two flops on every pin before logic sees it
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            sclk_s <= 2'b00;
            csn_s  <= 2'b11;
            din_s  <= 2'b00;
            sclk_q <= 1'b0;
            csn_q  <= 1'b1;
        end else begin
            sclk_s <= {sclk_s[0], serial_clk_i};
            csn_s  <= {csn_s[0], chip_sel_n_i};
            din_s  <= {din_s[0], serial_in_i};
            sclk_q <= sclk_s[1];
            csn_q  <= csn_s[1];
        end
    end

    // edge finders read only the second synchroniser stage
    assign rise      = sclk_s[1] & ~sclk_q & ~csn_s[1];
    assign fall      = ~sclk_s[1] & sclk_q & ~csn_s[1];
    assign cs_rise   = csn_s[1] & ~csn_q;
    assign cs_fall   = ~csn_s[1] & csn_q;
    assign opc_next  = {opcode[6:0], din_s[1]};
    assign addr_next = {addr[22:0], din_s[1]};
    assign unit_idx  = addr[UNIT_SHIFT+IDX_W-1:UNIT_SHIFT];
    assign mem_addr  = {addr[13:12] - 2'd1, addr[7:0]};

    // frame state machine, clocked by recovered serial clock edges
    always @(posedge clock_i) begin
        do_set_one <= 1'b0;
        do_clr_one <= 1'b0;
        do_set_all <= 1'b0;
        do_clr_all <= 1'b0;
        do_init    <= 1'b0;
        if (!rst_n_i) begin
            state     <= ST_OPC;
            bit_cnt   <= 5'd0;
            opcode    <= 8'h00;
            addr      <= 24'h00_0000;
            shift_out <= 8'h00;
            lock_read <= 1'b0;
            armed     <= 1'b0;
            we_latch  <= 1'b0;
            in_reset  <= 1'b0;
            rcnt      <= {RCNT_W{1'b0}};
            pend_one  <= 1'b0;
            pend_val  <= 1'b0;
            pend_all  <= 1'b0;
        end else if (in_reset) begin
            state   <= ST_OPC;
            bit_cnt <= 5'd0;
            if (rcnt == RESET_CYCLES - 1) begin
                in_reset <= 1'b0;
            end
            rcnt <= rcnt + 1'b1;
        end else if (cs_rise) begin
            state    <= ST_OPC;
            bit_cnt  <= 5'd0;
            pend_one <= 1'b0;
            pend_all <= 1'b0;
            if (pend_one) begin
                do_set_one <= pend_val;
                do_clr_one <= ~pend_val;
                we_latch   <= 1'b0;
            end
            if (pend_all) begin
                do_set_all <= pend_val;
                do_clr_all <= ~pend_val;
                we_latch   <= 1'b0;
            end
        end else if (cs_fall) begin
            state   <= ST_OPC;
            bit_cnt <= 5'd0;
        end else if (rise) begin
            case (state)
                ST_OPC: begin
                    opcode  <= opc_next;
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == `SFSL_OPCODE_BITS - 1) begin
                        bit_cnt <= 5'd0;
                        state   <= ST_IDLE;
                        armed <= (opc_next == `SFSL_OP_RESET_ARM);
                        case (opc_next)
                            `SFSL_OP_RESET_GO: begin
                                if (armed) begin
                                    in_reset <= 1'b1;
                                    rcnt     <= {RCNT_W{1'b0}};
                                    we_latch <= 1'b0;
                                    do_init  <= 1'b1;
                                end
                            end
                            `SFSL_OP_SECREG_READ: begin
                                if (!cycle_busy_i) begin
                                    state <= ST_ADDR;
                                end
                            end
                            `SFSL_OP_UNIT_LOCK,
                            `SFSL_OP_UNIT_UNLOCK,
                            `SFSL_OP_LOCK_READ: begin
                                state <= ST_ADDR;
                            end
                            `SFSL_OP_GLOBAL_LOCK,
                            `SFSL_OP_GLOBAL_UNLOCK: begin
                                pend_all <= we_latch;
                                pend_val <= (opc_next ==
                                             `SFSL_OP_GLOBAL_LOCK);
                            end
                            default: begin
                                state <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ADDR: begin
                    addr    <= addr_next;
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == `SFSL_ADDR_BITS - 1) begin
                        bit_cnt <= 5'd0;
                        state   <= ST_IDLE;
                        if (opcode == `SFSL_OP_SECREG_READ) begin
                            state <= ST_DUMMY;
                        end else if (opcode == `SFSL_OP_LOCK_READ) begin
                            state     <= ST_DATA;
                            lock_read <= 1'b1;
                        end else begin
                            pend_one <= we_latch;
                            pend_val <= (opcode == `SFSL_OP_UNIT_LOCK);
                        end
                    end
                end
                ST_DUMMY: begin
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == `SFSL_DUMMY_BITS - 1) begin
                        bit_cnt   <= 5'd0;
                        state     <= ST_DATA;
                        lock_read <= 1'b0;
                    end
                end
                ST_DATA: begin
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == 5'd7) begin
                        bit_cnt <= 5'd0;
                        addr[7:0] <= addr[7:0] + 8'd1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
        // write enable latch set by the outside write enable path
        if (rst_n_i && !in_reset && latch_set_i) begin
            we_latch <= 1'b1;
        end
    end

    // output shifter driven on falling edges
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else if (csn_s[1] || in_reset || state != ST_DATA) begin
            serial_out_oe_o <= 1'b0;
            serial_out_o    <= 1'b0;
            shift_out       <= 8'h00;
        end else if (fall) begin
            serial_out_oe_o <= 1'b1;
            if (bit_cnt == 5'd0) begin
                if (lock_read) begin
                    serial_out_o <= 1'b0;
                    shift_out    <= {6'h00, locks[unit_idx], 1'b0};
                end else begin
                    serial_out_o <= mem_q[7];
                    shift_out    <= {mem_q[6:0], 1'b0};
                end
            end else begin
                serial_out_o <= shift_out[7];
                shift_out    <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // registered status outputs
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            write_enable_latch_o <= 1'b0;
            busy_o               <= 1'b0;
            reset_pulse_o        <= 1'b0;
            protect_use_locks_o  <= 1'b0;
            lock_bits_o          <= {UNITS{1'b1}};
        end else begin
            write_enable_latch_o <= we_latch;
            busy_o               <= cycle_busy_i | in_reset;
            reset_pulse_o        <= do_init;
            // locks apply only in lock mode
            protect_use_locks_o  <= per_unit_lock_mode_i;
            lock_bits_o          <= locks;
        end
    end

    // security register banks; read address settles half a serial bit before the falling edge that loads it
    sfsl_secreg_mem #(
        .ADDR_W (10)
    ) u_mem (
        .clock_i   (clock_i),
        .wr_en_i   (secreg_wr_en_i),
        .wr_addr_i (secreg_wr_addr_i),
        .wr_data_i (secreg_wr_data_i),
        .rd_addr_i (mem_addr),
        .rd_data_o (mem_q)
    );

    // volatile lock store
    sfsl_lock_bits #(
        .UNITS (UNITS),
        .IDX_W (IDX_W)
    ) u_locks (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .init_i    (do_init),
        .set_one_i (do_set_one),
        .clr_one_i (do_clr_one),
        .set_all_i (do_set_all),
        .clr_all_i (do_clr_all),
        .idx_i     (unit_idx),
        .lock_o    (locks)
    );
endmodule // sfsl_sequencer

//--- verilog/sfsl_map.vh
/*
 * constants for the serial flash security register, lock and reset block:
 * opcodes, address fields, lock reset values and timing counts.
 * assumes a 250 MHz core clock sampling the serial pins.
 */
`ifndef SFSL_MAP_VH
`define SFSL_MAP_VH

// instruction opcodes
`define SFSL_OP_SECREG_READ   8'h48
`define SFSL_OP_UNIT_LOCK     8'h36
`define SFSL_OP_UNIT_UNLOCK   8'h39
`define SFSL_OP_LOCK_READ     8'h3D
`define SFSL_OP_GLOBAL_LOCK   8'h7E
`define SFSL_OP_GLOBAL_UNLOCK 8'h98
`define SFSL_OP_RESET_ARM     8'h66
`define SFSL_OP_RESET_GO      8'h99

// security register address fields
`define SFSL_SR_HI_BYTE       8'h00
`define SFSL_SR_SEL_MSB       15
`define SFSL_SR_SEL_LSB       12
`define SFSL_SR_SEL_ONE       4'h1
`define SFSL_SR_SEL_TWO       4'h2
`define SFSL_SR_SEL_THREE     4'h3
`define SFSL_SR_MID_ZERO      4'h0

// bit counts of the serial frame
`define SFSL_OPCODE_BITS      8
`define SFSL_ADDR_BITS        24
`define SFSL_DUMMY_BITS       8

// lock bit value after reset: locked
`define SFSL_LOCK_RESET       1'b1

// recovery period after an accepted reset
`define SFSL_RESET_TIME_NS    30000
`define SFSL_CLOCK_MHZ        250
`define SFSL_RESET_CYCLES     ((`SFSL_RESET_TIME_NS * `SFSL_CLOCK_MHZ) / 1000)

`endif

//--- verilog/sfsl_secreg_mem.v
/*
 * security register storage: four 256-byte banks, read data registered.
 * assumes a write port driven by the program path outside this block;
 * contents start at the erased value.
 */
`timescale 1ns/1ns
module sfsl_secreg_mem #(
    parameter ADDR_W = 10
) (
    input  wire              clock_i,
    input  wire              wr_en_i,
    input  wire [ADDR_W-1:0] wr_addr_i,
    input  wire [7:0]        wr_data_i,
    input  wire [ADDR_W-1:0] rd_addr_i,
    output reg  [7:0]        rd_data_o
);
    // storage array, no reset: contents are the stored data
    reg [7:0] mem [0:(1<<ADDR_W)-1];
    integer   k;

    // erased value at start, as an unprogrammed register reads
    initial begin
        for (k = 0; k < (1<<ADDR_W); k = k + 1) begin
            mem[k] = 8'hFF;
        end
    end

    // write port
    always @(posedge clock_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // registered read port
    always @(posedge clock_i) begin
        rd_data_o <= mem[rd_addr_i];
    end
endmodule // sfsl_secreg_mem

//--- verilog/sfsl_lock_bits.v
/*
 * volatile per-unit lock bits with single and global set and clear.
 * assumes one update request per cycle from the instruction decoder.
 */
`timescale 1ns/1ns
`include "sfsl_map.vh"
module sfsl_lock_bits #(
    parameter UNITS  = 32,
    parameter IDX_W  = 5
) (
    input  wire             clock_i,
    input  wire             rst_n_i,
    input  wire             init_i,
    input  wire             set_one_i,
    input  wire             clr_one_i,
    input  wire             set_all_i,
    input  wire             clr_all_i,
    input  wire [IDX_W-1:0] idx_i,
    output wire [UNITS-1:0] lock_o
);
    reg [UNITS-1:0] lock;    // one bit per block or sector
    genvar g;

    // per-unit flop; reset or device reset forces the locked state
    generate
        for (g = 0; g < UNITS; g = g + 1) begin : g_unit
            always @(posedge clock_i) begin
                if (!rst_n_i || init_i) begin
                    lock[g] <= `SFSL_LOCK_RESET;
                end else if (set_all_i) begin
                    lock[g] <= 1'b1;
                end else if (clr_all_i) begin
                    lock[g] <= 1'b0;
                end else if (set_one_i && idx_i == g) begin
                    lock[g] <= 1'b1;
                end else if (clr_one_i && idx_i == g) begin
                    lock[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign lock_o = lock;
endmodule // sfsl_lock_bits

//--- dv/sfsl_sequencer_sva.sv
/* checker for the flash sequencer ports: reset values, busy, locks, reset.
   assumes the serial pins change on core falling edges. */
`timescale 1ns/1ns
module sfsl_sequencer_sva #(
    parameter UNITS = 32
) (
    input wire             clock_i,
    input wire             rst_n_i,
    input wire             serial_clk_i,
    input wire             chip_sel_n_i,
    input wire             cycle_busy_i,
    input wire             per_unit_lock_mode_i,
    input wire             serial_out_o,
    input wire             serial_out_oe_o,
    input wire             write_enable_latch_o,
    input wire             busy_o,
    input wire             reset_pulse_o,
    input wire             protect_use_locks_o,
    input wire [UNITS-1:0] lock_bits_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // own disable: the antecedent is the reset itself
    reset_vals_a: assert property (disable iff (1'b0) !rst_n_i |=>
        (&lock_bits_o && !write_enable_latch_o && !serial_out_oe_o))
        else $error("reset values wrong");
    busy_follow_a: assert property (cycle_busy_i |=> busy_o)
        else $error("busy not reported");
    recov_busy_a: assert property (reset_pulse_o |-> ##2 busy_o [*8])
        else $error("busy missing in recovery");
    reset_locks_a: assert property (reset_pulse_o |-> ##[1:3]
        (&lock_bits_o && !write_enable_latch_o))
        else $error("reset left state behind");
    pulse_once_a: assert property (reset_pulse_o |=> !reset_pulse_o [*8])
        else $error("reset pulse repeated");
    cs_idle_a: assert property (chip_sel_n_i [*8] |-> !serial_out_oe_o)
        else $error("output driven while deselected");
    busy_refuse_a: assert property (cycle_busy_i [*8] |-> !serial_out_oe_o)
        else $error("read served while busy");
    lock_gate_a: assert property (($changed(lock_bits_o) &&
        !$past(reset_pulse_o) && !$past(reset_pulse_o, 2) &&
        !$past(reset_pulse_o, 3)) |->
        ($past(write_enable_latch_o) || $past(write_enable_latch_o, 2)))
        else $error("locks changed without latch");
    data_hold_a: assert property (serial_clk_i &&
        $past(serial_clk_i, 4) |-> $stable(serial_out_o))
        else $error("data moved while clock high");
    mode_copy_a: assert property ($stable(per_unit_lock_mode_i) |->
        protect_use_locks_o == per_unit_lock_mode_i)
        else $error("lock mode not followed");
    // main scenarios reached
    reset_seen_c: cover property (reset_pulse_o);
    read_seen_c: cover property ($rose(serial_out_oe_o));
    unlocked_c: cover property (lock_bits_o == {UNITS{1'b0}});
endmodule // sfsl_sequencer_sva
bind sfsl_sequencer sfsl_sequencer_sva #(.UNITS(UNITS)) i_sfsl_sequencer_sva (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .serial_clk_i(serial_clk_i),
    .chip_sel_n_i(chip_sel_n_i), .cycle_busy_i(cycle_busy_i),
    .per_unit_lock_mode_i(per_unit_lock_mode_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
    .write_enable_latch_o(write_enable_latch_o), .busy_o(busy_o),
    .reset_pulse_o(reset_pulse_o), .protect_use_locks_o(protect_use_locks_o),
    .lock_bits_o(lock_bits_o));

//--- dv/sfsl_host_model.sv
/* serial host model, clock idle low, 48 ns serial period.
   assumes frame() is called from one process at a time. */
`timescale 1ns/1ns
module sfsl_host_model (
    input  wire clock_i,
    input  wire serial_out_i,
    input  wire serial_out_oe_i,
    output reg  serial_clk_o,
    output reg  chip_sel_n_o,
    output reg  serial_in_o
);
    reg [7:0] rd [0:7];   // bytes seen after the address
    reg       oe_seen;    // output driven during the last frame
    // idle levels: clock stands still low outside frames
    initial begin
        serial_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        serial_in_o  = 1'b0;
        oe_seen      = 1'b0;
    end
    // half a serial period, counted on core falling edges
    task half;
        repeat (6) @(negedge clock_i);
    endtask
    // one byte each way
    task xbyte(input [7:0] b, output [7:0] r);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                // msb first, held across the rise
                serial_in_o = b[i];
                half;
                serial_clk_o = 1'b1;
                r[i] = serial_out_i;
                oe_seen = oe_seen | serial_out_oe_i;
                half;
                serial_clk_o = 1'b0;
            end
            // released line shows the inverse, not the last bit
            serial_in_o = ~b[0];
        end
    endtask
    // opcode, na address bytes, nx dummy or read bytes
    task frame(input [7:0] op, input [23:0] ad, input integer na,
               input integer nx);
        integer k;
        reg [7:0] junk;
        begin
            oe_seen = 1'b0;
            chip_sel_n_o = 1'b0;
            xbyte(op, junk);
            for (k = 0; k < na; k = k + 1)
                xbyte(ad[23-8*k -: 8], junk);
            for (k = 0; k < nx; k = k + 1)
                xbyte(8'h00, rd[k]);
            half;
            chip_sel_n_o = 1'b1;
            repeat (2) half;
        end
    endtask
endmodule // sfsl_host_model

//--- dv/serial_flash_secreg_lock_reset_bench.sv
/* self-checking bench for the flash sequencer with a serial host model.
   assumes 250 MHz core clock; recovery shortened to 600 cycles. */
`timescale 1ns/1ns
module serial_flash_secreg_lock_reset_bench;
    localparam RST_CYC = 600;   // short recovery for simulation
    reg         clock_i;
    reg         rst_n_i;
    reg         cycle_busy_i;
    reg         latch_set_i;
    reg         per_unit_lock_mode_i;
    reg         secreg_wr_en_i;
    reg  [9:0]  secreg_wr_addr_i;
    reg  [7:0]  secreg_wr_data_i;
    wire        serial_clk_i;
    wire        chip_sel_n_i;
    wire        serial_in_i;
    wire        serial_out_o;
    wire        serial_out_oe_o;
    wire        write_enable_latch_o;
    wire        busy_o;
    wire        reset_pulse_o;
    wire        protect_use_locks_o;
    wire [31:0] lock_bits_o;
    integer     n_errors;
    integer     total_checks;
    integer     n_pulse = 0;   // accepted resets seen
    integer     n;
    sfsl_sequencer #(.RESET_CYCLES(RST_CYC)) i_sfsl_sequencer (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .serial_clk_i(serial_clk_i),
        .chip_sel_n_i(chip_sel_n_i), .serial_in_i(serial_in_i),
        .cycle_busy_i(cycle_busy_i), .latch_set_i(latch_set_i),
        .per_unit_lock_mode_i(per_unit_lock_mode_i),
        .secreg_wr_en_i(secreg_wr_en_i), .secreg_wr_addr_i(secreg_wr_addr_i),
        .secreg_wr_data_i(secreg_wr_data_i), .serial_out_o(serial_out_o),
        .serial_out_oe_o(serial_out_oe_o),
        .write_enable_latch_o(write_enable_latch_o), .busy_o(busy_o),
        .reset_pulse_o(reset_pulse_o),
        .protect_use_locks_o(protect_use_locks_o), .lock_bits_o(lock_bits_o));
    sfsl_host_model i_sfsl_host_model (
        .clock_i(clock_i), .serial_out_i(serial_out_o),
        .serial_out_oe_i(serial_out_oe_o), .serial_clk_o(serial_clk_i),
        .chip_sel_n_o(chip_sel_n_i), .serial_in_o(serial_in_i));
    // core clock, 4 ns
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    // count reset pulses
    always @(posedge clock_i) begin
        if (reset_pulse_o === 1'b1) n_pulse <= n_pulse + 1;
    end
    task chk(input bit good, input string m);
        begin
            total_checks = total_checks + 1;
            if (!good) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0t %s", $time, m);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // one-cycle pulse on the latch set input
    task latch_pulse;
        begin
            @(negedge clock_i) latch_set_i = 1'b1;
            @(negedge clock_i) latch_set_i = 1'b0;
            @(negedge clock_i);
        end
    endtask
    task sr_wr(input [9:0] a, input [7:0] d);
        begin
            @(negedge clock_i);
            secreg_wr_en_i = 1'b1;
            secreg_wr_addr_i = a;
            secreg_wr_data_i = d;
            @(negedge clock_i) secreg_wr_en_i = 1'b0;
        end
    endtask
    task t_reset_state;
        chk(lock_bits_o === 32'hffff_ffff, "locks after reset");
    endtask
    // wrap inside register one, register three select, busy refusal
    task t_secreg;
        begin
            sr_wr(10'h0fe, 8'ha5);
            sr_wr(10'h0ff, 8'h3c);
            sr_wr(10'h000, 8'h96);
            sr_wr(10'h210, 8'h5a);
            i_sfsl_host_model.frame(8'h48, 24'h00_10fe, 3, 4);
            chk(i_sfsl_host_model.rd[1] === 8'ha5, "first byte");
            chk(i_sfsl_host_model.rd[3] === 8'h96, "wrap byte");
            i_sfsl_host_model.frame(8'h48, 24'h00_3010, 3, 3);
            chk(i_sfsl_host_model.rd[1] === 8'h5a, "register three");
            chk(i_sfsl_host_model.rd[2] === 8'hff, "erased byte");
            @(negedge clock_i) cycle_busy_i = 1'b1;
            i_sfsl_host_model.frame(8'h48, 24'h00_1000, 3, 2);
            chk(i_sfsl_host_model.oe_seen === 1'b0, "read while busy");
            chk(busy_o === 1'b1, "busy flag");
            cycle_busy_i = 1'b0;
        end
    endtask
    task t_locks;
        begin
            latch_pulse;
            i_sfsl_host_model.frame(8'h98, 24'h0, 0, 0);
            chk(lock_bits_o === 32'h0000_0000, "global unlock");
            i_sfsl_host_model.frame(8'h36, 24'h02_8000, 3, 0);
            chk(lock_bits_o === 32'h0000_0000, "lock without latch");
            latch_pulse;
            i_sfsl_host_model.frame(8'h36, 24'h02_8000, 3, 0);
            chk(lock_bits_o === 32'h0000_0020, "unit lock");
            i_sfsl_host_model.frame(8'h3d, 24'h02_8000, 3, 1);
            chk(i_sfsl_host_model.rd[0] === 8'h01, "read locked");
            i_sfsl_host_model.frame(8'h3d, 24'h03_0000, 3, 1);
            chk(i_sfsl_host_model.rd[0] === 8'h00, "read unlocked");
            latch_pulse;
            i_sfsl_host_model.frame(8'h39, 24'h02_8000, 3, 0);
            chk(lock_bits_o === 32'h0000_0000, "unit unlock");
            latch_pulse;
            i_sfsl_host_model.frame(8'h7e, 24'h0, 0, 0);
            chk(lock_bits_o === 32'hffff_ffff, "global lock");
            per_unit_lock_mode_i = 1'b1;
            repeat (3) @(negedge clock_i);
            chk(protect_use_locks_o === 1'b1, "lock mode");
        end
    endtask
    task t_sw_reset;
        begin
            latch_pulse;
            i_sfsl_host_model.frame(8'h98, 24'h0, 0, 0);
            latch_pulse;
            chk(write_enable_latch_o === 1'b1, "latch set");
            chk(busy_o === 1'b0, "idle before reset");
            i_sfsl_host_model.frame(8'h66, 24'h0, 0, 0);
            i_sfsl_host_model.frame(8'h3d, 24'h0, 3, 1);
            i_sfsl_host_model.frame(8'h99, 24'h0, 0, 0);
            chk(n_pulse === 0 && lock_bits_o === 32'h0, "disarm");
            i_sfsl_host_model.frame(8'h66, 24'h0, 0, 0);
            i_sfsl_host_model.frame(8'h99, 24'h0, 0, 0);
            chk(n_pulse === 1, "reset pulse");
            chk(lock_bits_o === 32'hffff_ffff, "locks on reset");
            chk(write_enable_latch_o === 1'b0, "latch on reset");
            chk(busy_o === 1'b1, "recovery busy");
            i_sfsl_host_model.frame(8'h3d, 24'h0, 3, 1);
            chk(i_sfsl_host_model.oe_seen === 1'b0, "recovery read");
            n = 0;
            while (busy_o !== 1'b0 && n < 2000) begin
                @(negedge clock_i);
                n = n + 1;
            end
            chk(busy_o === 1'b0, "recovery end");
        end
    endtask
    // watchdog, about six times the expected run
    initial begin
        #150000;
        n_errors = n_errors + 1;
        $display("MISMATCH %0t timeout", $time);
        close_out;
    end
    // main sequence
    initial begin
        n_errors = 0;
        total_checks = 0;
        rst_n_i = 1'b0;
        cycle_busy_i = 1'b0;
        latch_set_i = 1'b0;
        per_unit_lock_mode_i = 1'b0;
        secreg_wr_en_i = 1'b0;
        secreg_wr_addr_i = 10'h000;
        secreg_wr_data_i = 8'h00;
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        t_reset_state;
        t_secreg;
        t_locks;
        t_sw_reset;
        close_out;
    end
endmodule // serial_flash_secreg_lock_reset_bench
